/* File: hdl/ddr4_cmd_addr_pin_decode.sv */
`timescale 1ns/100ps
module ddr4_cmd_addr_pin_decode
	import ddr4_cmd_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              reset,
	input  wire logic              dev_reset_n,
	input  wire pin_s              pins,
	input  wire logic              nominal_termination_enable,
	input  wire logic [ADDR_W-1:0] mode_reg_five,
	input  wire logic              rd_valid,
	input  wire logic [DQ_W-1:0]   rd_data,
	output      cmd_out_s          cmd_ff,
	output      pwr_state_e        pwr_state_ff,
	output      logic              core_clk_en_ff,
	output      logic              ck_buf_en_ff,
	output      logic              ca_buf_en_ff,
	output      logic              term_buf_en_ff,
	output      logic              term_on_ff,
	output      logic [BANKS-1:0]  open_banks_ff,
	output      logic [LANES-1:0]  wr_beat_valid_ff,
	output      logic [DQ_W-1:0]   wr_beat_data_ff,
	output      logic [DQ_W-1:0]   dq_o_ff,
	output      logic              dq_oe_ff,
	output      logic [LANES-1:0]  invert_o_n_ff,
	output      logic              invert_oe_ff
);
	// either reset source clears the block
	logic rst_any;
	assign rst_any = reset | ~dev_reset_n;
	// counts zero bits of a byte above the inversion limit
	function automatic logic many_zeros(input logic [7:0] b);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++)
		begin
			n = n + {3'h0, ~b[i]};
		end
		return n > DBI_ZERO_LIMIT;
	endfunction : many_zeros
	// pin synchroniser stages and filtered pin image
	pin_s       sync_ff [SYNC_STAGES];
	pin_s       filt_ff;
	pin_s       nxt_filt;
	pin_s       en_mask;
	logic       ck_prev_ff;
	logic       ck_rise;
	logic [1:0] strobe_prev_ff;
	// buffers that stay live in each power state
	always_comb
	begin
		en_mask = '0;
		en_mask.cke = 1'b1;
		if (pwr_state_ff != pwr_self_refresh)
		begin
			en_mask.ck_t = 1'b1;
			en_mask.ck_c = 1'b1;
			en_mask.term_ctl_in = 1'b1;
		end
		if (pwr_state_ff == pwr_active)
		begin
			en_mask = '1;
		end
		// a bit updates once stages two and three agree and its buffer is live
		nxt_filt = (sync_ff[2] & ~(sync_ff[1] ^ sync_ff[2]) & en_mask)
			| (filt_ff & ((sync_ff[1] ^ sync_ff[2]) | ~en_mask));
	end
	// crossing of true clock high and complement low
	assign ck_rise = filt_ff.ck_t & ~filt_ff.ck_c & ~ck_prev_ff;
	// synchroniser and filter registers
	always_ff @(posedge mclk or posedge rst_any)
	begin
		if (rst_any)
		begin
			sync_ff[0]     <= '0;
			sync_ff[1]     <= '0;
			sync_ff[2]     <= '0;
			filt_ff        <= '0;
			ck_prev_ff     <= 1'b0;
			strobe_prev_ff <= '0;
		end
		else
		begin
			sync_ff[0]     <= pins;
			sync_ff[1]     <= sync_ff[0];
			sync_ff[2]     <= sync_ff[1];
			filt_ff        <= nxt_filt;
			ck_prev_ff     <= filt_ff.ck_t & ~filt_ff.ck_c;
			strobe_prev_ff <= filt_ff.strobe;
		end
	end
	// command decode, bank tracking and power state
	ca_bus_s          ca;
	logic [2:0]       code;
	logic [2:0]       bidx;
	cmd_out_s         nxt_cmd;
	pwr_state_e       nxt_pwr;
	logic [BANKS-1:0] nxt_open;
	logic             nxt_term;
	assign ca   = filt_ff.ca;
	assign code = {ca.row_strobe_or_addr_hi, ca.col_strobe_or_addr_mid, ca.write_en_or_addr_lo};
	assign bidx = {ca.group_sel, ca.bank_sel};
	always_comb
	begin
		nxt_cmd  = '0;
		nxt_pwr  = pwr_state_ff;
		nxt_open = open_banks_ff;
		nxt_term = term_on_ff & nominal_termination_enable;
		// fields carried with every command
		nxt_cmd.group_sel = ca.group_sel;
		nxt_cmd.bank_sel  = ca.bank_sel;
		nxt_cmd.row       = {code, ca.addr_bus};
		nxt_cmd.col       = ca.addr_bus;
		nxt_cmd.kind      = cmd_none;
		if (ck_rise && pwr_state_ff != pwr_self_refresh)
		begin
			// termination follows its pin unless disabled by nominal_termination_enable
			nxt_term = filt_ff.term_ctl_in & nominal_termination_enable;
		end
		unique case (pwr_state_ff)
			pwr_active:
			begin
				if (ck_rise && !ca.cs_n)
				begin
					nxt_cmd.valid = 1'b1;
					if (!ca.activate_n)
					begin
						nxt_cmd.kind   = cmd_act;
						nxt_open[bidx] = 1'b1;
					end
					else
					begin
						// multiplexed pins read as a command code
						unique case (code)
							CODE_RD:  nxt_cmd.kind = cmd_rd;
							CODE_WR:  nxt_cmd.kind = cmd_wr;
							CODE_PRE: nxt_cmd.kind = cmd_pre;
							CODE_MRS: nxt_cmd.kind = cmd_mrs;
							CODE_REF: nxt_cmd.kind = cmd_ref;
							default:  nxt_cmd.kind = cmd_other;
						endcase
					end
					if (nxt_cmd.kind == cmd_rd || nxt_cmd.kind == cmd_wr)
					begin
						nxt_cmd.autopre = ca.addr_bus[AUTOPRE_POS];
						nxt_cmd.chop    = ~ca.addr_bus[CHOP_POS];
						if (ca.addr_bus[AUTOPRE_POS])
						begin
							nxt_open[bidx] = 1'b0;
						end
					end
					if (nxt_cmd.kind == cmd_pre)
					begin
						nxt_cmd.all_banks = ca.addr_bus[AUTOPRE_POS];
						if (ca.addr_bus[AUTOPRE_POS])
						begin
							nxt_open = '0;
						end
						else
						begin
							nxt_open[bidx] = 1'b0;
						end
					end
				end
				// gating low picks the power-down flavour
				if (ck_rise && !filt_ff.cke)
				begin
					if (!ca.cs_n && ca.activate_n && code == CODE_REF)
					begin
						nxt_pwr = pwr_self_refresh;
					end
					else if (|open_banks_ff)
					begin
						nxt_pwr = pwr_act_pd;
					end
					else
					begin
						nxt_pwr = pwr_pre_pd;
					end
				end
			end
			pwr_pre_pd, pwr_act_pd:
			begin
				if (ck_rise && filt_ff.cke)
				begin
					nxt_pwr = pwr_active;
				end
			end
			pwr_self_refresh:
			begin
				// exit seen on the gating pin alone
				if (filt_ff.cke)
				begin
					nxt_pwr = pwr_active;
				end
			end
		endcase
	end
	// command, power state and buffer enable registers
	always_ff @(posedge mclk or posedge rst_any)
	begin
		if (rst_any)
		begin
			cmd_ff         <= '0;
			pwr_state_ff   <= pwr_active;
			open_banks_ff  <= '0;
			term_on_ff     <= 1'b0;
			core_clk_en_ff <= 1'b1;
			ck_buf_en_ff   <= 1'b1;
			ca_buf_en_ff   <= 1'b1;
			term_buf_en_ff <= 1'b1;
		end
		else
		begin
			cmd_ff         <= nxt_cmd;
			pwr_state_ff   <= nxt_pwr;
			open_banks_ff  <= nxt_open;
			term_on_ff     <= nxt_term;
			core_clk_en_ff <= nxt_pwr == pwr_active;
			ck_buf_en_ff   <= nxt_pwr != pwr_self_refresh;
			ca_buf_en_ff   <= nxt_pwr == pwr_active;
			term_buf_en_ff <= nxt_pwr != pwr_self_refresh;
		end
	end
	// write beats and read drive, one generate lane per byte
	logic [LANES-1:0] nxt_wvalid;
	logic [DQ_W-1:0]  nxt_wdata;
	logic [DQ_W-1:0]  nxt_dq;
	logic [LANES-1:0] nxt_inv_n;
	logic             dm_mode;
	logic             wr_dbi;
	logic             rd_dbi;
	logic             drive;
	assign dm_mode = mode_reg_five[MR5_DM_POS];
	assign wr_dbi  = mode_reg_five[MR5_WR_DBI_POS];
	assign rd_dbi  = mode_reg_five[MR5_RD_DBI_POS];
	assign drive   = rd_valid & (pwr_state_ff == pwr_active);
	for (genvar g = 0; g < LANES; g++)
	begin : g_lane
		logic       edge_seen;
		logic       inv_in;
		logic       inv_out;
		logic [7:0] din;
		assign din       = filt_ff.dq[8*g +: 8];
		assign edge_seen = (filt_ff.strobe[g] ^ strobe_prev_ff[g]) & ca_buf_en_ff;
		assign inv_in    = wr_dbi & ~dm_mode & ~filt_ff.mask_n[g];
		assign inv_out   = rd_dbi & many_zeros(rd_data[8*g +: 8]);
		// both strobe edges carry a beat; masked beats are dropped
		assign nxt_wvalid[g] = edge_seen & ~(dm_mode & ~filt_ff.mask_n[g]);
		assign nxt_wdata[8*g +: 8] = inv_in ? ~din : din;
		assign nxt_dq[8*g +: 8]    = inv_out ? ~rd_data[8*g +: 8] : rd_data[8*g +: 8];
		assign nxt_inv_n[g]        = ~inv_out;
	end
	// data path registers
	always_ff @(posedge mclk or posedge rst_any)
	begin
		if (rst_any)
		begin
			wr_beat_valid_ff <= '0;
			wr_beat_data_ff  <= '0;
			dq_o_ff          <= '0;
			dq_oe_ff         <= 1'b0;
			invert_o_n_ff    <= '1;
			invert_oe_ff     <= 1'b0;
		end
		else
		begin
			wr_beat_valid_ff <= nxt_wvalid;
			wr_beat_data_ff  <= nxt_wdata;
			dq_o_ff          <= drive ? nxt_dq : '0;
			dq_oe_ff         <= drive;
			invert_o_n_ff    <= drive ? nxt_inv_n : '1;
			invert_oe_ff     <= drive & rd_dbi;
		end
	end
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst_any);

	a_cmd_on_edge: assert property (cmd_ff.valid |-> $past(ck_rise))
		else $error("command taken without clock crossing");
	a_gate_drops: assert property ($fell(core_clk_en_ff) |-> $past(ck_rise && !filt_ff.cke))
		else $error("clocks gated without gating pin low");
	a_pd_flavour: assert property ((pwr_state_ff == pwr_active)
		##1 (pwr_state_ff == pwr_act_pd) |-> $past(|open_banks_ff))
		else $error("active power-down with all banks idle");
	a_sr_exit: assert property ((pwr_state_ff == pwr_self_refresh) && filt_ff.cke
		|=> pwr_state_ff == pwr_active)
		else $error("self-refresh exit missed");
	a_pd_buffers: assert property ((pwr_state_ff inside {pwr_pre_pd, pwr_act_pd})
		|-> ck_buf_en_ff && term_buf_en_ff && !ca_buf_en_ff)
		else $error("wrong buffers live in power-down");
	a_sr_buffers: assert property ((pwr_state_ff == pwr_self_refresh)
		|-> !ck_buf_en_ff && !term_buf_en_ff && !ca_buf_en_ff)
		else $error("buffer live in self-refresh");
	a_cs_masks: assert property (ck_rise && ca.cs_n |=> !cmd_ff.valid)
		else $error("command accepted with chip select high");
	a_term_gate: assert property (!nominal_termination_enable [*2] |-> !term_on_ff)
		else $error("termination on while disabled");
	a_act_row: assert property (cmd_ff.valid && cmd_ff.kind == cmd_act
		|-> cmd_ff.row[ROW_W-1 -: 3] == $past(code))
		else $error("activate row high bits wrong");
	a_mask_drop: assert property (g_lane[0].edge_seen && dm_mode && !filt_ff.mask_n[0]
		|=> !wr_beat_valid_ff[0])
		else $error("masked beat kept");
	a_pre_all: assert property (cmd_ff.valid && cmd_ff.kind == cmd_pre && cmd_ff.all_banks
		|-> open_banks_ff == '0)
		else $error("banks open after precharge all");

	c_act_read: cover property (cmd_ff.valid && cmd_ff.kind == cmd_act
		##[1:200] cmd_ff.valid && cmd_ff.kind == cmd_rd);
	c_self_refresh: cover property (pwr_state_ff == pwr_self_refresh ##[1:200] pwr_state_ff == pwr_active);
	c_act_pd: cover property (pwr_state_ff == pwr_act_pd);
	c_wr_beat: cover property (|wr_beat_valid_ff);
endmodule : ddr4_cmd_addr_pin_decode

/* File: hdl/ddr4_cmd_pkg.sv */
package ddr4_cmd_pkg;
	// address pins that are not multiplexed with command pins
	localparam int ADDR_W      = 14;
	localparam int ROW_W       = 17;
	localparam int DQ_W        = 16;
	localparam int LANES       = 2;
	localparam int BANKS       = 8;
	localparam int SYNC_STAGES = 3;
	// field positions in the address word
	localparam int AUTOPRE_POS = 10;
	localparam int CHOP_POS    = 12;
	// mode_reg_five opcode bits steering the shared mask pin
	localparam int MR5_DM_POS     = 10;
	localparam int MR5_WR_DBI_POS = 11;
	localparam int MR5_RD_DBI_POS = 12;
	// zero count above which a read byte is sent inverted
	localparam logic [3:0] DBI_ZERO_LIMIT = 4'h4;
	// non-activate command codes on {row strobe, col strobe, write enable}
	localparam logic [2:0] CODE_MRS = 3'h0;
	localparam logic [2:0] CODE_REF = 3'h1;
	localparam logic [2:0] CODE_PRE = 3'h2;
	localparam logic [2:0] CODE_WR  = 3'h4;
	localparam logic [2:0] CODE_RD  = 3'h5;

	typedef enum logic [2:0] {cmd_none, cmd_act, cmd_rd, cmd_wr, cmd_pre, cmd_mrs,
		cmd_ref, cmd_other} cmd_kind_e;
	typedef enum logic [1:0] {pwr_active, pwr_pre_pd, pwr_act_pd, pwr_self_refresh} pwr_state_e;

	// command/address pins, sampled together
	typedef struct packed {
		logic              cs_n;
		logic              activate_n;
		logic              row_strobe_or_addr_hi;
		logic              col_strobe_or_addr_mid;
		logic              write_en_or_addr_lo;
		logic              group_sel;
		logic [1:0]        bank_sel;
		logic [ADDR_W-1:0] addr_bus;
	} ca_bus_s;

	// every pin that crosses into the mclk domain
	typedef struct packed {
		logic              ck_t;
		logic              ck_c;
		logic              cke;
		logic              term_ctl_in;
		ca_bus_s           ca;
		logic [LANES-1:0]  mask_n;
		logic [LANES-1:0]  strobe;
		logic [DQ_W-1:0]   dq;
	} pin_s;

	// one decoded command
	typedef struct packed {
		logic              valid;
		cmd_kind_e         kind;
		logic              group_sel;
		logic [1:0]        bank_sel;
		logic [ROW_W-1:0]  row;
		logic [ADDR_W-1:0] col;
		logic              autopre;
		logic              chop;
		logic              all_banks;
	} cmd_out_s;
endpackage : ddr4_cmd_pkg

/* File: test/ddr4_ctrl_model.sv */
`timescale 1ns/100ps
// controller side: drives the clock pair and the command pins
module ddr4_ctrl_model
	import ddr4_cmd_pkg::*;
(
	input  wire logic mclk,
	output      pin_s pins
);
	// half of one 320 ns link period
	task automatic half();
		repeat (4) @(negedge mclk);
	endtask : half
	// one framed command; the clock stands still between frames
	task automatic cmd(input ca_bus_s ca);
		// let an edge pass after the previous frame's release
		@(negedge mclk);
		pins.ca = ca;
		half();
		half();
		pins.ck_t = 1'b1;
		pins.ck_c = 1'b0;
		half();
		pins.ck_t = 1'b0;
		pins.ck_c = 1'b1;
		half();
		// released pins: deselected, the rest inverted
		pins.ca      = ~ca;
		pins.ca.cs_n = 1'b1;
	endtask : cmd
	// idle levels, clock-gating held high through accesses
	initial
	begin
		pins         = '0;
		pins.ck_c    = 1'b1;
		pins.cke     = 1'b1;
		pins.ca.cs_n = 1'b1;
		pins.mask_n  = 2'h3;
	end
endmodule : ddr4_ctrl_model

/* File: test/ddr4_cmd_addr_pin_decode_tb.sv */
`timescale 1ns/100ps
module ddr4_cmd_addr_pin_decode_tb;
	import ddr4_cmd_pkg::*;
	logic              mclk = 1'b0;
	logic              reset = 1'b1;
	logic              dev_reset_n = 1'b1;
	logic              nominal_termination_enable = 1'b1;
	logic [ADDR_W-1:0] mode_reg_five = '0;
	logic              rd_valid = 1'b0;
	logic [DQ_W-1:0]   rd_data = '0;
	pin_s              pins;
	cmd_out_s          cmd_ff;
	cmd_out_s          last;
	pwr_state_e        pwr_state_ff;
	logic              core_clk_en_ff, ck_buf_en_ff, ca_buf_en_ff, term_buf_en_ff;
	logic              term_on_ff, dq_oe_ff, invert_oe_ff;
	logic [BANKS-1:0]  open_banks_ff;
	logic [LANES-1:0]  wr_beat_valid_ff, invert_o_n_ff;
	logic [DQ_W-1:0]   wr_beat_data_ff, dq_o_ff, beat_data;
	int                num_errors = 0;
	int                cmp_count = 0;
	int                n_cmd = 0;
	int                n_beat [LANES] = '{0, 0};

	always #20 mclk = ~mclk;

	ddr4_cmd_addr_pin_decode ddr4_cmd_addr_pin_decode_i (.mclk, .reset, .dev_reset_n, .pins,
		.nominal_termination_enable, .mode_reg_five, .rd_valid, .rd_data, .cmd_ff, .pwr_state_ff,
		.core_clk_en_ff, .ck_buf_en_ff, .ca_buf_en_ff, .term_buf_en_ff, .term_on_ff,
		.open_banks_ff, .wr_beat_valid_ff, .wr_beat_data_ff, .dq_o_ff, .dq_oe_ff,
		.invert_o_n_ff, .invert_oe_ff);
	ddr4_ctrl_model ddr4_ctrl_model_i (.mclk(mclk), .pins(pins));

	// record decoded commands and accepted write beats
	always @(posedge mclk)
	begin
		if (cmd_ff.valid === 1'b1)
		begin
			last = cmd_ff;
			n_cmd++;
		end
		for (int l = 0; l < LANES; l++)
			if (wr_beat_valid_ff[l] === 1'b1)
			begin
				n_beat[l]++;
				beat_data = wr_beat_data_ff;
			end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// command word: cs low, activate_n, mux pins, {group, bank}, address
	function automatic ca_bus_s ca(input logic an, input logic [2:0] m, input logic [2:0] gb,
		input logic [ADDR_W-1:0] a);
		ca = {1'b0, an, m, gb, a};
	endfunction : ca

	task automatic go(input ca_bus_s c);
		ddr4_ctrl_model_i.cmd(c);
	endtask : go

	task automatic nap(input int n);
		repeat (n) @(negedge mclk);
	endtask : nap

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test

	// watchdog well beyond the expected run of about 19 us
	initial
	begin
		#200000;
		num_errors++;
		finish_test();
	end

	initial
	begin
		ca_bus_s c;
		nap(20);
		reset = 1'b0;
		nap(1);
		chk(pwr_state_ff, pwr_active);
		chk({core_clk_en_ff, ck_buf_en_ff, ca_buf_en_ff, term_buf_en_ff}, 4'hf);
		chk({term_on_ff, open_banks_ff, dq_oe_ff, invert_o_n_ff}, 12'h003);
		nap(4);
		$display("reset test done");
		// activate: mux pins become row bits 16..14
		go(ca(1'b0, 3'h5, 3'h6, 14'h1234));
		chk(n_cmd, 1);
		chk(last.kind, cmd_act);
		chk(last.row, {3'h5, 14'h1234});
		chk({last.group_sel, last.bank_sel}, 3'h6);
		chk(open_banks_ff, 8'h40);
		// selected pins with no clock crossing, then a deselected command
		nap(1);
		ddr4_ctrl_model_i.pins.ca = ca(1'b1, CODE_RD, 3'h6, 14'h0000);
		nap(16);
		chk(n_cmd, 1);
		c = ca(1'b1, CODE_PRE, 3'h6, 14'h0400);
		c.cs_n = 1'b1;
		go(c);
		chk(n_cmd, 1);
		chk(open_banks_ff, 8'h40);
		$display("activate test done");
		// read with auto precharge and chopped burst
		go(ca(1'b1, CODE_RD, 3'h6, 14'h0400));
		chk(last.kind, cmd_rd);
		chk({last.autopre, last.chop, last.col}, {2'h3, 14'h0400});
		chk(open_banks_ff, 8'h00);
		go(ca(1'b1, CODE_WR, 3'h1, 14'h1000));
		chk({last.kind, last.autopre, last.chop}, {cmd_wr, 2'h0});
		go(ca(1'b1, CODE_MRS, 3'h5, 14'h0abc));
		chk({last.kind, last.group_sel, last.bank_sel}, {cmd_mrs, 3'h5});
		chk(last.col, 14'h0abc);
		go(ca(1'b1, CODE_REF, 3'h0, 14'h0000));
		chk(last.kind, cmd_ref);
		go(ca(1'b1, 3'h7, 3'h0, 14'h0000));
		chk(last.kind, cmd_other);
		$display("command test done");
		// single bank and all bank precharge
		go(ca(1'b0, 3'h0, 3'h1, 14'h0010));
		go(ca(1'b0, 3'h0, 3'h6, 14'h0020));
		go(ca(1'b1, CODE_PRE, 3'h1, 14'h0000));
		chk({last.kind, last.all_banks}, {cmd_pre, 1'b0});
		chk(open_banks_ff, 8'h40);
		go(ca(1'b1, CODE_PRE, 3'h0, 14'h0400));
		chk({last.all_banks, open_banks_ff}, 9'h100);
		$display("precharge test done");
		// termination follows its pin only while enabled
		c.cs_n = 1'b1;
		ddr4_ctrl_model_i.pins.term_ctl_in = 1'b1;
		go(c);
		chk(term_on_ff, 1'b1);
		nominal_termination_enable = 1'b0;
		go(c);
		chk(term_on_ff, 1'b0);
		$display("termination test done");
		// active power-down with a bank open, commands ignored there
		go(ca(1'b0, 3'h0, 3'h2, 14'h0030));
		ddr4_ctrl_model_i.pins.cke = 1'b0;
		go(c);
		chk(pwr_state_ff, pwr_act_pd);
		chk({core_clk_en_ff, ck_buf_en_ff, ca_buf_en_ff, term_buf_en_ff}, 4'h5);
		go(ca(1'b1, CODE_PRE, 3'h0, 14'h0400));
		chk(open_banks_ff, 8'h04);
		ddr4_ctrl_model_i.pins.cke = 1'b1;
		go(c);
		chk(pwr_state_ff, pwr_active);
		go(ca(1'b1, CODE_PRE, 3'h0, 14'h0400));
		ddr4_ctrl_model_i.pins.cke = 1'b0;
		go(c);
		chk(pwr_state_ff, pwr_pre_pd);
		// output drivers stay off while powered down
		rd_valid = 1'b1;
		nap(1);
		rd_valid = 1'b0;
		chk(dq_oe_ff, 1'b0);
		ddr4_ctrl_model_i.pins.cke = 1'b1;
		go(c);
		// self refresh, left with no clock edge at all
		ddr4_ctrl_model_i.pins.cke = 1'b0;
		go(ca(1'b1, CODE_REF, 3'h0, 14'h0000));
		chk(pwr_state_ff, pwr_self_refresh);
		chk({core_clk_en_ff, ck_buf_en_ff, ca_buf_en_ff, term_buf_en_ff}, 4'h0);
		ddr4_ctrl_model_i.pins.cke = 1'b1;
		nap(10);
		chk(pwr_state_ff, pwr_active);
		$display("power test done");
		// masked lower lane dropped, then lower lane inverted
		mode_reg_five = 14'h0400;
		ddr4_ctrl_model_i.pins.dq = 16'h5aa5;
		ddr4_ctrl_model_i.pins.mask_n = 2'h2;
		ddr4_ctrl_model_i.pins.strobe = 2'h3;
		nap(8);
		chk({n_beat[0][3:0], n_beat[1][3:0]}, 8'h01);
		mode_reg_five = 14'h0800;
		ddr4_ctrl_model_i.pins.strobe = 2'h0;
		nap(8);
		chk({n_beat[0][3:0], n_beat[1][3:0], beat_data}, 24'h12_5a5a);
		// mask wins over inversion, then a masked falling strobe edge
		mode_reg_five = 14'h0c00;
		ddr4_ctrl_model_i.pins.dq = 16'h3cc3;
		ddr4_ctrl_model_i.pins.strobe = 2'h3;
		nap(8);
		chk({n_beat[0][3:0], n_beat[1][3:0], beat_data}, 24'h13_3cc3);
		mode_reg_five = 14'h0400;
		ddr4_ctrl_model_i.pins.strobe = 2'h0;
		nap(8);
		chk({n_beat[0][3:0], n_beat[1][3:0]}, 8'h14);
		$display("write test done");
		// read bytes with more than four zeros go out inverted
		mode_reg_five = 14'h1000;
		rd_data = 16'h00ff;
		rd_valid = 1'b1;
		nap(1);
		rd_valid = 1'b0;
		chk({dq_oe_ff, invert_oe_ff, invert_o_n_ff, dq_o_ff}, 20'hd_ffff);
		nap(2);
		chk(dq_oe_ff, 1'b0);
		// read inversion off: data and flag go out plain
		mode_reg_five = 14'h0000;
		rd_valid = 1'b1;
		nap(1);
		rd_valid = 1'b0;
		chk({dq_oe_ff, invert_oe_ff, invert_o_n_ff, dq_o_ff}, 20'hb_00ff);
		$display("read test done");
		// device reset acts without a clock edge
		go(ca(1'b0, 3'h0, 3'h3, 14'h0040));
		dev_reset_n = 1'b0;
		#5;
		chk(open_banks_ff, 8'h00);
		$display("device reset test done");
		finish_test();
	end
endmodule : ddr4_cmd_addr_pin_decode_tb
